// ===== hw/flash_guard_params.svh
// Constants for the flash write and erase guard
`ifndef FLASH_GUARD_PARAMS_SVH
`define FLASH_GUARD_PARAMS_SVH
`define ADR_PSC 4'h0
`define ADR_MON 4'h1
`define ADR_RSRC 4'h2
`define ADR_CLK 4'h3
`define ADR_IST 4'h4
`define ADR_IMSK 4'h5
`define ADR_XADDR 4'h6
`define ADR_XDATA 4'h7
`define BIT_WE 0
`define BIT_EE 1
`define BIT_MON_EN 0
`define BIT_MON_RST 1
`define BIT_POR 1
`define BIT_FERR 6
`define PSC_RESET 8'h00
`define PSC_MASK 8'h03
`define MON_RESET 2'h0
`define CLK_RESET 2'h2
`define POR_RESET 1'b1
`define OP_TIME_NS 40
`define CLK_PERIOD_NS 10
`define OP_CYCLES ((`OP_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define EV_DONE 0
`define EV_REFUSED 1
`define EV_HELD 2
`endif

// ===== hw/flash_guard_pkg.sv
// Types for the flash write and erase guard
package flash_guard_pkg;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_BUSY = 2'b01,
        ST_FAULT = 2'b10
    } op_state_t;
    typedef struct packed {
        logic erase;
        logic [15:0] addr;
        logic [7:0] data;
    } flash_req_t;
endpackage : flash_guard_pkg

// ===== hw/flash_op_timer.sv
// Flash operation sequencer with pending timer
`timescale 1ns/1ps
`default_nettype none
`include "flash_guard_params.svh"
module flash_op_timer (
    input wire logic clk, // Core clock
    input wire logic rst_n, // Async reset, active low
    input wire logic launch, // Start operation pulse
    input wire logic fault, // Launch is illegal
    output logic busy, // Operation in progress
    output logic done, // One-cycle completion pulse
    output logic fault_out // One-cycle error pulse
);
    localparam logic [7:0] OP_CYC = 8'(`OP_CYCLES);
    flash_guard_pkg::op_state_t state, next_state; // Sequencer state
    logic [7:0] cnt, next_cnt; // Remaining cycles
    logic next_done, next_fault; // Next pulse values
    // Next state of the sequencer
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_done = 1'b0;
        next_fault = 1'b0;
        unique case (state)
            flash_guard_pkg::ST_IDLE: begin
                if (launch && fault) begin
                    next_state = flash_guard_pkg::ST_FAULT;
                end else if (launch) begin
                    next_state = flash_guard_pkg::ST_BUSY;
                    next_cnt = OP_CYC;
                end
            end
            flash_guard_pkg::ST_BUSY: begin
                if (cnt <= 8'h01) begin
                    next_state = flash_guard_pkg::ST_IDLE;
                    next_done = 1'b1;
                end else begin
                    next_cnt = cnt - 8'h01;
                end
            end
            flash_guard_pkg::ST_FAULT: begin
                next_state = flash_guard_pkg::ST_IDLE;
                next_fault = 1'b1;
            end
            default: next_state = flash_guard_pkg::ST_IDLE;
        endcase
    end
    // Register the sequencer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= flash_guard_pkg::ST_IDLE;
            cnt <= 8'h00;
            done <= 1'b0;
            fault_out <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            done <= next_done;
            fault_out <= next_fault;
        end
    end
    assign busy = (state != flash_guard_pkg::ST_IDLE);
endmodule : flash_op_timer
`default_nettype wire

// ===== hw/flash_write_erase_guard.sv
// Flash write and erase guard with Wishbone register access
`timescale 1ns/1ps
`default_nettype none
`include "flash_guard_params.svh"
module flash_write_erase_guard (
    input wire logic CORE_CLK, // System clock
    input wire logic RST_N, // Async reset, active low
    input wire logic WB_CYC_I, // Wishbone cycle
    input wire logic WB_STB_I, // Wishbone strobe
    input wire logic WB_WE_I, // Wishbone write
    input wire logic [3:0] WB_ADR_I, // Register word index
    input wire logic [7:0] WB_DAT_I, // Write data
    input wire logic WB_SEL_I, // Byte select
    output logic [7:0] WB_DAT_O, // Read data
    output logic WB_ACK_O, // Acknowledge
    input wire logic CPU_IRQ_REQ, // Interrupt request from peripherals
    output logic CPU_IRQ, // Interrupt to core, held in flash op
    output logic FLASH_WR, // Flash byte program pulse
    output logic FLASH_ER, // Flash page erase pulse
    output logic [15:0] FLASH_ADDR, // Flash target address
    output logic [7:0] FLASH_DATA, // Flash program data
    output logic ERROR_RESET, // Flash error device reset pulse
    output logic CLK_SEL_INT, // System clock from internal oscillator
    output logic EXT_OSC_EN, // External oscillator keeps running
    output logic IRQ // Block interrupt, level
);
    ////////////////////////////////////////////////////////////////////////
    // Register state
    // Software visible registers
    logic [7:0] psc, next_psc; // Program store control
    logic [1:0] mon, next_mon; // Supply monitor enable, reset source
    logic ferr, next_ferr; // Flash error flag
    logic por, next_por; // Power-on flag
    logic [1:0] clk_cfg, next_clk_cfg; // Internal select, ext osc enable
    logic [2:0] ist, next_ist; // Sticky event status
    logic [2:0] imsk, next_imsk; // Interrupt mask
    logic [15:0] xaddr, next_xaddr; // Move target address
    // Bus and interrupt pipeline
    logic irq_sync1, irq_sync2; // Interrupt request synchroniser
    logic ack, next_ack; // Bus acknowledge
    logic [7:0] rdat, next_rdat; // Read data
    // Links to the sequencer, decode and events
    logic launch, fault, busy, done, fault_pulse; // Sequencer links
    flash_guard_pkg::flash_req_t req, next_req; // Latched request
    logic cpu_irq, next_cpu_irq; // Gated interrupt
    logic irq_q, next_irq; // Block interrupt
    logic wb_req, wr_hit, rd_hit; // Bus decode
    logic [2:0] ev; // Events this cycle

    ////////////////////////////////////////////////////////////////////////
    // Decode helpers

    // True for a taken write to the data move index
    function automatic logic data_move_hit(input logic hit, input logic [3:0] adr);
        return hit && (adr == `ADR_XDATA);
    endfunction : data_move_hit

    ////////////////////////////////////////////////////////////////////////
    // Bus decode
    // Ack is registered, so a request is taken only while ack is low;
    // a request held through its ack cycle is never taken twice
    assign wb_req = WB_CYC_I && WB_STB_I && !ack;
    assign wr_hit = wb_req && WB_WE_I && WB_SEL_I;
    assign rd_hit = wb_req && !WB_WE_I;

    // Data move write starts an op only with write enable set
    assign launch = data_move_hit(wr_hit, WB_ADR_I) && !busy
                    && psc[`BIT_WE];
    // Monitor bits are looked at only as the op launches, so a later
    // change of them cannot race the check
    assign fault = !(mon[`BIT_MON_EN] && mon[`BIT_MON_RST]);

    // Events: done, refused write, interrupt held
    // Each event sets a sticky status bit below
    always_comb begin
        ev = 3'h0;
        ev[`EV_DONE] = done;
        ev[`EV_REFUSED] = data_move_hit(wr_hit, WB_ADR_I) && !psc[`BIT_WE];
        ev[`EV_HELD] = busy && irq_sync2;
    end

    ////////////////////////////////////////////////////////////////////////
    // Next register values
    always_comb begin
        next_psc = psc;
        next_mon = mon;
        next_ferr = ferr;
        next_por = por;
        next_clk_cfg = clk_cfg;
        next_imsk = imsk;
        next_xaddr = xaddr;
        next_req = req;
        next_ack = wb_req;
        next_rdat = 8'h00;
        next_ist = ist;
        // Register writes, one per taken bus cycle
        if (wr_hit) begin
            unique case (WB_ADR_I)
                `ADR_PSC: next_psc = WB_DAT_I & `PSC_MASK;
                `ADR_MON: next_mon = WB_DAT_I[1:0];
                `ADR_RSRC: next_por = next_por & ~WB_DAT_I[`BIT_POR];
                `ADR_CLK: next_clk_cfg = WB_DAT_I[1:0];
                `ADR_IST: next_ist = ist & ~WB_DAT_I[2:0];
                `ADR_IMSK: next_imsk = WB_DAT_I[2:0];
                `ADR_XADDR: next_xaddr = {xaddr[7:0], WB_DAT_I};
                default: ;
            endcase
        end
        // Freeze target and data at launch so the strobes below pair with the request
        // that started them, except that a launch in the done cycle gives them the new target and data
        if (launch) begin
            next_req.erase = psc[`BIT_EE] && psc[`BIT_WE];
            next_req.addr = xaddr;
            next_req.data = WB_DAT_I;
        end
        // Error flag falls only with the async reset RST_N, not with ERROR_RESET
        if (fault_pulse) begin
            next_ferr = 1'b1;
        end
        // Events are or-ed in after the clear, so a set in the same cycle wins
        next_ist = next_ist | ev; // Set wins over clear
        // Read data stands for the one cycle of ack
        if (rd_hit) begin
            unique case (WB_ADR_I)
                `ADR_PSC: next_rdat = psc;
                `ADR_MON: next_rdat = {6'h00, mon};
                `ADR_RSRC: next_rdat = {1'b0, ferr, 4'h0, por, 1'b0};
                `ADR_CLK: next_rdat = {6'h00, clk_cfg};
                `ADR_IST: next_rdat = {5'h00, ist};
                `ADR_IMSK: next_rdat = {5'h00, imsk};
                `ADR_XADDR: next_rdat = xaddr[7:0];
                default: next_rdat = 8'h00;
            endcase
        end
        // Interrupts held while busy, released on done or on the fault pulse
        // A request that drops while busy is lost: the synchroniser only follows the level
        next_cpu_irq = irq_sync2 && !busy && !launch;
        next_irq = |(next_ist & imsk);
    end

    ////////////////////////////////////////////////////////////////////////
    // Register update
    // Only constants in the reset branch; every next value except the two synchroniser flops comes from above
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            // Power-on flag starts set, clock starts on the external source
            psc <= `PSC_RESET;
            mon <= `MON_RESET;
            ferr <= 1'b0;
            por <= `POR_RESET;
            clk_cfg <= `CLK_RESET;
            ist <= 3'h0;
            imsk <= 3'h0;
            xaddr <= 16'h0000;
            req <= '0;
            ack <= 1'b0;
            rdat <= 8'h00;
            irq_sync1 <= 1'b0;
            irq_sync2 <= 1'b0;
            cpu_irq <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            psc <= next_psc;
            mon <= next_mon;
            ferr <= next_ferr;
            por <= next_por;
            clk_cfg <= next_clk_cfg;
            ist <= next_ist;
            imsk <= next_imsk;
            xaddr <= next_xaddr;
            req <= next_req;
            ack <= next_ack;
            rdat <= next_rdat;
            // Two flops before any logic reads the request pin
            irq_sync1 <= CPU_IRQ_REQ;
            irq_sync2 <= irq_sync1;
            cpu_irq <= next_cpu_irq;
            irq_q <= next_irq;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Operation sequencer
    // Owns the op timing and the one-cycle done and fault pulses
    flash_op_timer u_timer (
        .clk(CORE_CLK),
        .rst_n(RST_N),
        .launch(launch),
        .fault(fault),
        .busy(busy),
        .done(done),
        .fault_out(fault_pulse)
    );

    // Output registers for flash strobes
    // Strobes trail done or the fault pulse by one cycle so they leave from flip-flops
    logic fwr, fer, erst; // Registered strobes
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            fwr <= 1'b0;
            fer <= 1'b0;
            erst <= 1'b0;
        end else begin
            fwr <= done && !req.erase;
            fer <= done && req.erase;
            erst <= fault_pulse;
        end
    end

    // Outputs, each straight from a flip-flop
    // Error reset only pulses; the block runs on, so the error flag stays
    assign WB_DAT_O = rdat;
    assign WB_ACK_O = ack;
    assign CPU_IRQ = cpu_irq;
    assign FLASH_WR = fwr;
    assign FLASH_ER = fer;
    assign FLASH_ADDR = req.addr;
    assign FLASH_DATA = req.data;
    assign ERROR_RESET = erst;
    assign CLK_SEL_INT = clk_cfg[0];
    assign EXT_OSC_EN = clk_cfg[1];
    assign IRQ = irq_q;
endmodule : flash_write_erase_guard
`default_nettype wire

// ===== sim/flash_model.sv
// Flash array model behind the program and erase strobes
`timescale 1ns/1ps
`default_nettype none
module flash_model (
    input wire logic clk, // Clock
    input wire logic wr, // Program pulse
    input wire logic er, // Erase pulse
    input wire logic [15:0] adr, // Target address
    input wire logic [7:0] din, // Program data
    input wire logic [3:0] radr, // Peek index
    output logic [7:0] q // Peek data
);
    logic [7:0] mem [16]; // Small page of cells
    assign q = mem[radr];
    // Erase sets the page, program only clears bits
    always @(posedge clk) begin
        if (er) begin
            for (int i = 0; i < 16; i++) mem[i] <= 8'hff;
        end else if (wr) begin
            mem[adr[3:0]] <= mem[adr[3:0]] & din;
        end
    end
endmodule : flash_model
`default_nettype wire

// ===== sim/flash_guard_properties.sv
// Concurrent checks on the flash guard ports
`timescale 1ns/1ps
`default_nettype none
`include "flash_guard_params.svh"
module flash_guard_props (
    input wire logic CORE_CLK, // Clock
    input wire logic RST_N, // Reset, active low
    input wire logic WB_CYC_I, // Cycle
    input wire logic WB_STB_I, // Strobe
    input wire logic WB_WE_I, // Write
    input wire logic [3:0] WB_ADR_I, // Index
    input wire logic WB_SEL_I, // Select
    input wire logic [7:0] WB_DAT_O, // Read data
    input wire logic WB_ACK_O, // Ack
    input wire logic CPU_IRQ, // Core interrupt
    input wire logic FLASH_WR, // Program pulse
    input wire logic FLASH_ER, // Erase pulse
    input wire logic ERROR_RESET // Error reset
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);
    logic launch; // Data move write answered
    logic [3:0] cnt; // Cycles since launch
    logic [3:0] next_cnt; // Next count
    assign launch = WB_ACK_O && WB_CYC_I && WB_STB_I && WB_WE_I && WB_SEL_I
        && WB_ADR_I == `ADR_XDATA;
    // Count from launch, saturating
    always_comb begin
        next_cnt = (cnt == 4'hf) ? cnt : cnt + 4'h1;
        if (launch) begin
            next_cnt = 4'h0;
        end
    end
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            cnt <= 4'hf;
        end else begin
            cnt <= next_cnt;
        end
    end
    a_ack_single: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack too long");
    a_op_excl: assert property (!(FLASH_WR && FLASH_ER))
        else $error("both pulses");
    a_op_cause: assert property ((FLASH_WR || FLASH_ER) |-> cnt inside {[2:8]})
        else $error("op without launch");
    a_err_cause: assert property (ERROR_RESET |-> cnt <= 4'h2)
        else $error("late error");
    a_err_blocks: assert property (ERROR_RESET |-> !(FLASH_WR || FLASH_ER) [*6])
        else $error("flash changed");
    a_wr_pulse: assert property (FLASH_WR |=> !FLASH_WR)
        else $error("long program");
    a_irq_held: assert property ((FLASH_WR || FLASH_ER) |-> !$past(CPU_IRQ, 1)
        && !$past(CPU_IRQ, 2) && !$past(CPU_IRQ, 3)) else $error("irq leaked");
    a_psc_upper: assert property (WB_ACK_O && !WB_WE_I && WB_ADR_I == `ADR_PSC
        |-> WB_DAT_O[7:2] == 6'h00) else $error("control upper bits");
    c_prog: cover property (FLASH_WR);
    c_erase: cover property (FLASH_ER);
    c_err: cover property (ERROR_RESET);
endmodule : flash_guard_props
bind flash_write_erase_guard flash_guard_props u_props (
    .CORE_CLK(CORE_CLK),
    .RST_N(RST_N),
    .WB_CYC_I(WB_CYC_I),
    .WB_STB_I(WB_STB_I),
    .WB_WE_I(WB_WE_I),
    .WB_ADR_I(WB_ADR_I),
    .WB_SEL_I(WB_SEL_I),
    .WB_DAT_O(WB_DAT_O),
    .WB_ACK_O(WB_ACK_O),
    .CPU_IRQ(CPU_IRQ),
    .FLASH_WR(FLASH_WR),
    .FLASH_ER(FLASH_ER),
    .ERROR_RESET(ERROR_RESET)
);
`default_nettype wire

// ===== sim/tb_top.sv
// Self-checking bench for the flash guard
`timescale 1ns/1ps
`default_nettype none
`include "flash_guard_params.svh"
module tb_top;
    logic clk, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, req = 1'b0; // Drives
    logic [3:0] adr = 4'h0; // Index
    logic [7:0] wdat = 8'h00, rdat, q; // Bus and peek data
    logic ack, cpu_irq, fwr, fer, err, csel, eosc, irq; // Outputs
    logic [15:0] fadr; // Flash address
    logic [7:0] fdat; // Flash data
    int error_cnt = 0, n_tests = 0, ticks = 0; // Counters
    flash_write_erase_guard uut (.CORE_CLK(clk), .RST_N(rst_n), .WB_CYC_I(cyc),
        .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_DAT_I(wdat), .WB_SEL_I(1'b1),
        .WB_DAT_O(rdat), .WB_ACK_O(ack), .CPU_IRQ_REQ(req), .CPU_IRQ(cpu_irq),
        .FLASH_WR(fwr), .FLASH_ER(fer), .FLASH_ADDR(fadr), .FLASH_DATA(fdat),
        .ERROR_RESET(err), .CLK_SEL_INT(csel), .EXT_OSC_EN(eosc), .IRQ(irq));
    flash_model fm (.clk(clk), .wr(fwr), .er(fer), .adr(fadr), .din(fdat), .radr(4'h4), .q(q));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Hang guard
    always @(posedge clk) begin
        ticks++;
        if (ticks == 5000) begin
            error_cnt++;
            wrap_up();
        end
    end
    task automatic wrap_up();
        if (error_cnt == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [7:0] g, input logic [7:0] e, input string m);
        n_tests++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch %0t %s", $time, m);
        end
    endtask : chk
    // Classic single Wishbone cycle
    task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d,
        output logic [7:0] r);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        // Ack ends this wait; only the hang guard ends it if ack never comes
        do @(posedge clk); while (ack !== 1'b1);
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic [7:0] r;
        wb(1'b1, a, d, r);
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        logic [7:0] r;
        wb(1'b0, a, 8'h00, r);
        chk(r, e, "read");
    endtask : rd
    // Watch one strobe for a while
    task automatic pulse(input int k, input logic e);
        logic s = 1'b0;
        repeat (12) begin
            @(posedge clk);
            if ((k == 0 ? fwr : k == 1 ? fer : err) === 1'b1) s = 1'b1;
        end
        chk({7'h0, s}, {7'h0, e}, "strobe");
    endtask : pulse
    task automatic t_regs();
        rd(`ADR_PSC, 8'h00);
        rd(`ADR_CLK, 8'h02);
        rd(4'h9, 8'h00);
        wr(`ADR_PSC, 8'hff);
        rd(`ADR_PSC, 8'h03);
        wr(`ADR_CLK, 8'h03);
        chk({6'h0, csel, eosc}, 8'h03, "clock");
        wr(`ADR_CLK, 8'h02);
        chk({6'h0, csel, eosc}, 8'h01, "clock back");
    endtask : t_regs
    task automatic t_erase();
        wr(`ADR_MON, 8'h03);
        wr(`ADR_XADDR, 8'h12);
        wr(`ADR_XADDR, 8'h34);
        wr(`ADR_XDATA, 8'h00);
        pulse(1, 1'b1);
        chk(q, 8'hff, "erase");
        rd(`ADR_IST, 8'h01);
        wr(`ADR_IST, 8'hff);
    endtask : t_erase
    task automatic t_write();
        wr(`ADR_PSC, 8'h01);
        req <= 1'b1;
        wr(`ADR_XDATA, 8'h5a);
        wr(`ADR_MON, 8'h00);
        chk({7'h0, cpu_irq}, 8'h00, "irq held");
        pulse(0, 1'b1);
        chk(fadr[15:8], 8'h12, "addr");
        chk(q, 8'h5a, "cell");
        chk({7'h0, cpu_irq}, 8'h01, "irq after");
        req <= 1'b0;
        rd(`ADR_IST, 8'h05);
        chk({7'h0, irq}, 8'h00, "masked");
        wr(`ADR_IMSK, 8'h01);
        repeat (2) @(posedge clk);
        chk({7'h0, irq}, 8'h01, "irq set");
        wr(`ADR_IST, 8'h07);
        repeat (2) @(posedge clk);
        chk({7'h0, irq}, 8'h00, "irq clear");
    endtask : t_write
    task automatic t_fault();
        wr(`ADR_MON, 8'h03);
        wr(`ADR_PSC, 8'h00);
        wr(`ADR_XDATA, 8'h11);
        pulse(0, 1'b0);
        rd(`ADR_IST, 8'h02);
        wr(`ADR_MON, 8'h01);
        wr(`ADR_PSC, 8'h01);
        wr(`ADR_XDATA, 8'h22);
        pulse(2, 1'b1);
        chk(q, 8'h5a, "kept");
        rd(`ADR_RSRC, 8'h42);
        wr(`ADR_RSRC, 8'h42);
        rd(`ADR_RSRC, 8'h40);
    endtask : t_fault
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        t_erase();
        t_write();
        t_fault();
        wrap_up();
    end
endmodule : tb_top
`default_nettype wire
